//--- cta_parser.sv
`timescale 1ns/10ps
// Functional notes
// - Element is length byte, identifier byte, then one or more blocks.
// - Length byte counts the whole element including itself.
// - Block has attribute at offset zero, microsecond start at offset one.
// - Start times count from the command packet preamble start.
// - Attribute bits 7:6 give block type: receive, transmit, notify, reserved.
// - Receive and transmit blocks carry endpoint number in attribute bits 3:0.
// - Bit 5 flags setup stage; eight setup bytes follow the block.
// - Notification blocks have bits 5:0 zero; device ignores them.
// - Device listens throughout a receive slot addressed to it.
// - Device transmits within a transmit slot addressed to it.
// - In a notification slot only device notifications are sent.
// - Transmit bit 4: zero OUT endpoint handshakes, one IN endpoint answers.
// - Data blocks carry device address at offset three; act only on own.
module cta_parser (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_preamble,
  input wire logic i_ie_valid,
  input wire logic i_ie_first,
  input wire logic [7:0] i_ie_data,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_rx_listen,
  output logic o_tx_slot,
  output logic o_tx_in_ep,
  output logic o_dn_slot,
  output logic [3:0] o_slot_ep,
  output logic o_slot_setup,
  output logic [63:0] o_setup_data,
  output logic o_setup_valid
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    cta_pkg::cta_fsm_t fsm;
    logic [7:0] len;
    logic [7:0] cnt;
    logic [7:0] attr;
    logic [15:0] start;
    logic mine;
    logic [2:0] sidx;
    logic [63:0] setup;
    logic [63:0] setup_out;
    logic [3:0] n;
    // Foreign blocks are kept too, since they still bound the slots
    logic [cta_pkg::TBL_DEPTH-1:0][15:0] tb_start;
    logic [cta_pkg::TBL_DEPTH-1:0][7:0] tb_attr;
    logic [cta_pkg::TBL_DEPTH-1:0] tb_mine;
    logic [3:0] cur;
    logic [2:0] slot;
    logic act;
    logic [6:0] cyc;
    logic [15:0] us;
    logic [7:0] dev_addr;
    logic en;
    logic len_err;
    logic ovf;
    logic rsv;
    logic [31:0] rdata;
    logic rx;
    logic tx;
    logic in_ep;
    logic dn;
    logic [3:0] ep;
    logic slot_setup;
    logic setup_vld;
  } cta_state_t;

  cta_state_t s_q;
  cta_state_t s_d;

  function automatic logic [1:0] blk_type(input logic [7:0] a);
    return a[cta_pkg::TYPE_LSB +: 2];
  endfunction : blk_type

  function automatic logic is_data(input logic [7:0] a);
    return (blk_type(a) == cta_pkg::TYPE_RX) || (blk_type(a) == cta_pkg::TYPE_TX);
  endfunction : is_data

  function automatic logic [3:0] ep_of(input logic [7:0] a);
    return a[cta_pkg::EP_LSB +: cta_pkg::EP_W];
  endfunction : ep_of

  function automatic logic setup_of(input logic [7:0] a);
    return a[cta_pkg::SETUP_BIT];
  endfunction : setup_of

  function automatic logic in_of(input logic [7:0] a);
    return a[cta_pkg::DIR_BIT];
  endfunction : in_of

  // Unused status bits read zero so the map can grow later
  function automatic logic [31:0] status_word(input cta_state_t s);
    logic [31:0] w;
    w = 32'h00000000;
    w[cta_pkg::ST_CNT_LSB +: 4] = s.n;
    w[cta_pkg::ST_LEN_ERR] = s.len_err;
    w[cta_pkg::ST_OVF] = s.ovf;
    w[cta_pkg::ST_RSV] = s.rsv;
    w[cta_pkg::ST_ACT] = s.act;
    return w;
  endfunction : status_word

  function automatic logic [31:0] ctrl_word(input cta_state_t s);
    logic [31:0] w;
    w = 32'h00000000;
    w[cta_pkg::CTRL_ADDR_LSB +: 8] = s.dev_addr;
    w[cta_pkg::CTRL_EN_BIT] = s.en;
    return w;
  endfunction : ctrl_word

  function automatic logic [31:0] reg_read(input logic [7:0] a, input cta_state_t s);
    logic [31:0] w;
    w = 32'h00000000;
    case (a)
      cta_pkg::REG_CTRL: begin
        w = ctrl_word(s);
      end
      cta_pkg::REG_STATUS: begin
        w = status_word(s);
      end
      default: begin
        w = 32'h00000000;
      end
    endcase
    return w;
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////
  // An entry is due once the time base has reached its start time
  logic [cta_pkg::TBL_DEPTH-1:0] due;

  for (genvar k = 0; k < cta_pkg::TBL_DEPTH; k++) begin : g_due
    assign due[k] = (s_q.us >= s_q.tb_start[k]);
  end : g_due

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic last;
    logic commit;
    logic [16:0] slot_end;
    logic [2:0] nx;
    logic [7:0] sa;
    logic sm;
    logic tick;
    logic full;
    logic wr_ctrl;

    last = 1'b0;
    commit = 1'b0;
    slot_end = 17'h00000;
    nx = 3'h0;
    sa = 8'h00;
    sm = 1'b0;
    tick = 1'b0;
    full = 1'b0;
    wr_ctrl = 1'b0;

    s_d = s_q;
    s_d.setup_vld = 1'b0;

    // Register port
    wr_ctrl = i_wr && (i_addr == cta_pkg::REG_CTRL);
    if (wr_ctrl) begin
      s_d.dev_addr = i_wdata[cta_pkg::CTRL_ADDR_LSB +: 8];
      s_d.en = i_wdata[cta_pkg::CTRL_EN_BIT];
    end
    s_d.rdata = 32'h00000000;
    if (i_rd) begin
      s_d.rdata = reg_read(i_addr, s_q);
    end

    // Microsecond time base restarts at each command preamble
    tick = (s_q.cyc == cta_pkg::CYC_LAST);
    if (i_preamble) begin
      s_d.cyc = 7'h00;
      s_d.us = 16'h0000;
    end else if (tick) begin
      s_d.cyc = 7'h00;
      // Saturates rather than wraps, so a late slot never reopens early
      if (s_q.us != cta_pkg::US_MAX) begin
        s_d.us = s_q.us + 16'h0001;
      end
    end else begin
      s_d.cyc = s_q.cyc + 7'h01;
    end

    // Element parser; one element per command is assumed, a new first byte restarts
    if (i_ie_valid && i_ie_first) begin
      s_d.len = i_ie_data;
      s_d.cnt = 8'h01;
      s_d.n = 4'h0;
      s_d.cur = 4'h0;
      s_d.act = 1'b0;
      s_d.ovf = 1'b0;
      s_d.rsv = 1'b0;
      // A short element cannot hold even one block, so it is dropped whole
      s_d.len_err = (i_ie_data < cta_pkg::MIN_IE_LEN);
      s_d.fsm = (i_ie_data < cta_pkg::MIN_IE_LEN) ? cta_pkg::S_IDLE : cta_pkg::S_ID;
    end else if (i_ie_valid && s_q.fsm != cta_pkg::S_IDLE) begin
      s_d.cnt = s_q.cnt + 8'h01;
      // Final byte index is one below the length
      last = (s_q.cnt == s_q.len - 8'h01);
      case (s_q.fsm)
        cta_pkg::S_ID: begin
          s_d.fsm = cta_pkg::S_ATTR;
        end
        cta_pkg::S_ATTR: begin
          s_d.attr = i_ie_data;
          if (blk_type(i_ie_data) == cta_pkg::TYPE_RSV) begin
            // Layout of a reserved block is unknown, so the rest is dropped
            s_d.rsv = 1'b1;
            s_d.fsm = cta_pkg::S_SKIP;
          end else begin
            s_d.fsm = cta_pkg::S_SLO;
          end
        end
        cta_pkg::S_SLO: begin
          s_d.start[7:0] = i_ie_data;
          s_d.fsm = cta_pkg::S_SHI;
        end
        cta_pkg::S_SHI: begin
          s_d.start[15:8] = i_ie_data;
          if (is_data(s_q.attr)) begin
            s_d.fsm = cta_pkg::S_DEV;
          end else begin
            s_d.mine = 1'b1;
            commit = 1'b1;
            s_d.fsm = cta_pkg::S_ATTR;
          end
        end
        cta_pkg::S_DEV: begin
          // Foreign blocks are stored as well, they still end the slot before them
          s_d.mine = s_q.en && (i_ie_data == s_q.dev_addr);
          commit = 1'b1;
          s_d.sidx = 3'h0;
          s_d.fsm = s_q.attr[cta_pkg::SETUP_BIT] ? cta_pkg::S_SETUP : cta_pkg::S_ATTR;
        end
        cta_pkg::S_SETUP: begin
          s_d.setup[{s_q.sidx, 3'h0} +: 8] = i_ie_data;
          s_d.sidx = s_q.sidx + 3'h1;
          if (s_q.sidx == cta_pkg::SETUP_LAST) begin
            s_d.setup_vld = s_q.mine;
            // Bytes are staged so a foreign block leaves the output word alone
            if (s_q.mine) begin
              s_d.setup_out = s_d.setup;
            end
            s_d.fsm = cta_pkg::S_ATTR;
          end
        end
        cta_pkg::S_SKIP: begin
          // Reserved layout is unknown; wait here until the length runs out
          s_d.fsm = cta_pkg::S_SKIP;
        end
        default: begin
          s_d.fsm = cta_pkg::S_IDLE;
        end
      endcase
      full = (s_q.n == cta_pkg::TBL_FULL);
      if (commit) begin
        // A block beyond the table depth is flagged, not stored
        if (full) begin
          s_d.ovf = 1'b1;
        end else begin
          s_d.tb_start[s_q.n[2:0]] = s_d.start;
          s_d.tb_attr[s_q.n[2:0]] = s_q.attr;
          s_d.tb_mine[s_q.n[2:0]] = s_d.mine;
          s_d.n = s_q.n + 4'h1;
        end
      end
      if (last) begin
        // Element ending inside a block means the length was wrong
        if (s_d.fsm != cta_pkg::S_ATTR && s_d.fsm != cta_pkg::S_SKIP) begin
          s_d.len_err = 1'b1;
        end
        s_d.fsm = cta_pkg::S_IDLE;
      end
    end

    // Slot scheduler: a slot runs until the next start, the last one for a fixed span
    slot_end = {1'b0, s_q.tb_start[s_q.slot]} + cta_pkg::LAST_SLOT_US;
    nx = s_q.cur[2:0];
    if (!(i_ie_valid && i_ie_first)) begin
      // One entry opens per cycle; starts a microsecond apart never collide
      if (s_q.cur < s_q.n && due[nx]) begin
        s_d.act = 1'b1;
        s_d.slot = nx;
        s_d.cur = s_q.cur + 4'h1;
      end else if (s_q.act && s_q.cur >= s_q.n && {1'b0, s_q.us} >= slot_end) begin
        s_d.act = 1'b0;
      end
    end

    // Slot outputs; blocks for other devices still bound the slot but drive nothing
    sa = s_q.tb_attr[s_d.slot];
    sm = s_q.tb_mine[s_d.slot];
    s_d.rx = s_d.act && sm && blk_type(sa) == cta_pkg::TYPE_RX;
    s_d.tx = s_d.act && sm && blk_type(sa) == cta_pkg::TYPE_TX;
    s_d.dn = s_d.act && blk_type(sa) == cta_pkg::TYPE_DN;
    if (s_d.rx || s_d.tx) begin
      s_d.ep = ep_of(sa);
      s_d.slot_setup = setup_of(sa);
      s_d.in_ep = s_d.tx && in_of(sa);
    end else begin
      s_d.ep = 4'h0;
      s_d.slot_setup = 1'b0;
      s_d.in_ep = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
      s_q.fsm <= cta_pkg::S_IDLE;
      // Address field and state have their own reset constants, the rest clears
      s_q.dev_addr <= cta_pkg::CTRL_ADDR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_rdata = s_q.rdata;
  assign o_rx_listen = s_q.rx;
  assign o_tx_slot = s_q.tx;
  assign o_tx_in_ep = s_q.in_ep;
  assign o_dn_slot = s_q.dn;
  assign o_slot_ep = s_q.ep;
  assign o_slot_setup = s_q.slot_setup;
  assign o_setup_data = s_q.setup_out;
  assign o_setup_valid = s_q.setup_vld;

endmodule : cta_parser

//--- cta_pkg.sv
package cta_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam logic [6:0] CYC_LAST = 7'(CYC_PER_US - 1);
  localparam logic [15:0] US_MAX = 16'hffff;

  // Element layout
  localparam logic [7:0] HDR_LEN = 8'h02;
  localparam logic [7:0] MIN_IE_LEN = 8'h05;
  localparam logic [2:0] SETUP_LAST = 3'h7;

  // Attribute byte fields
  localparam int unsigned TYPE_LSB = 6;
  localparam int unsigned SETUP_BIT = 5;
  localparam int unsigned DIR_BIT = 4;
  localparam int unsigned EP_LSB = 0;
  localparam int unsigned EP_W = 4;

  // Block type codes
  localparam logic [1:0] TYPE_RX = 2'h0;
  localparam logic [1:0] TYPE_TX = 2'h1;
  localparam logic [1:0] TYPE_DN = 2'h2;
  localparam logic [1:0] TYPE_RSV = 2'h3;

  // Slot table
  localparam int unsigned TBL_DEPTH = 8;
  localparam logic [3:0] TBL_FULL = 4'h8;
  localparam logic [16:0] LAST_SLOT_US = 17'h00100;

  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int unsigned CTRL_ADDR_LSB = 0;
  localparam int unsigned CTRL_EN_BIT = 8;
  localparam logic [7:0] CTRL_ADDR_RST = 8'h00;
  localparam int unsigned ST_CNT_LSB = 0;
  localparam int unsigned ST_LEN_ERR = 4;
  localparam int unsigned ST_OVF = 5;
  localparam int unsigned ST_RSV = 6;
  localparam int unsigned ST_ACT = 7;

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_ID    = 8'h02,
    S_ATTR  = 8'h04,
    S_SLO   = 8'h08,
    S_SHI   = 8'h10,
    S_DEV   = 8'h20,
    S_SETUP = 8'h40,
    S_SKIP  = 8'h80
  } cta_fsm_t;

endpackage : cta_pkg

//--- cta_chk.sv
`timescale 1ns/10ps
module cta_chk (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic o_rx_listen,
  input wire logic o_tx_slot,
  input wire logic o_tx_in_ep,
  input wire logic o_dn_slot,
  input wire logic [3:0] o_slot_ep,
  input wire logic o_slot_setup,
  input wire logic o_setup_valid
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_own;
    o_rx_listen || o_tx_slot;
  endsequence
  // A new setup block needs at least twelve more bytes
  sequence s_quiet;
    !o_setup_valid [*8];
  endsequence
  a_rx_tx_excl: assert property (!(o_rx_listen && o_tx_slot))
    else $error("receive and transmit slot together");
  a_dn_only: assert property (o_dn_slot |-> !(o_rx_listen || o_tx_slot))
    else $error("data slot during notification slot");
  a_ep_own: assert property (o_slot_ep != 4'h0 |-> s_own)
    else $error("endpoint shown outside own slot");
  a_dn_bits: assert property (o_dn_slot |-> o_slot_ep == 4'h0 && !o_slot_setup)
    else $error("notification slot shows attribute bits");
  a_setup_own: assert property (o_slot_setup |-> s_own)
    else $error("setup flag outside own slot");
  a_setup_gap: assert property (o_setup_valid |=> s_quiet)
    else $error("setup pulses too close");
  a_in_ep_tx: assert property (o_tx_in_ep |-> o_tx_slot)
    else $error("responder select outside transmit slot");
  // Start times rise by at least one microsecond, so a slot lasts that long
  a_tx_hold: assert property ($rose(o_tx_slot) |=> o_tx_slot [*8])
    else $error("transmit slot too short");
endmodule : cta_chk
bind cta_parser cta_chk i_chk (.*);

//--- cta_host.sv
`timescale 1ns/10ps
module cta_host (
  input wire logic i_clk,
  output logic o_preamble,
  output logic o_valid,
  output logic o_first,
  output logic [7:0] o_data
);
  logic busy;
  initial begin
    o_preamble = 1'b0;
    o_valid = 1'b0;
    o_first = 1'b0;
    o_data = 8'h5a;
    busy = 1'b0;
  end
  // Idle bytes keep changing so a stale byte never looks valid
  always @(posedge i_clk) begin
    if (!busy) o_data <= ~o_data;
  end
  //////////////////////////////////////////////////////////////////////
  // One preamble, then one element: never two elements per command
  task send_mmc(input logic [7:0] body[$], input int len_ovr);
    logic [7:0] len;
    len = (len_ovr > 0) ? 8'(len_ovr) : 8'(body.size() + 1);
    busy = 1'b1;
    @(posedge i_clk);
    o_preamble <= 1'b1;
    @(posedge i_clk);
    o_preamble <= 1'b0;
    o_valid <= 1'b1;
    o_first <= 1'b1;
    o_data <= len;
    foreach (body[k]) begin
      @(posedge i_clk);
      o_first <= 1'b0;
      o_data <= body[k];
    end
    @(posedge i_clk);
    o_valid <= 1'b0;
    busy = 1'b0;
  endtask : send_mmc
endmodule : cta_host

//--- tb.sv
`timescale 1ns/10ps
module tb;
  logic clk, rstn, pre, ie_v, ie_f, wr, rd, rx, tx, tx_in, dn, s_set, s_val, rx_seen;
  logic [7:0] ie_d, addr;
  logic [31:0] wdata, rdata;
  logic [3:0] ep;
  logic [63:0] s_data, cap;
  logic [7:0] el[$];
  int err_count, checks_done, cyc, t_pre, seen;
  cta_parser i_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_preamble(pre), .i_ie_valid(ie_v),
    .i_ie_first(ie_f), .i_ie_data(ie_d), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_rx_listen(rx), .o_tx_slot(tx), .o_tx_in_ep(tx_in),
    .o_dn_slot(dn), .o_slot_ep(ep), .o_slot_setup(s_set), .o_setup_data(s_data),
    .o_setup_valid(s_val));
  cta_host i_host (.i_clk(clk), .o_preamble(pre), .o_valid(ie_v), .o_first(ie_f),
    .o_data(ie_d));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (pre) t_pre = cyc;
    if (rx) rx_seen = 1'b1;
    if (s_val) begin
      seen++;
      cap = s_data;
    end
  end
  //////////////////////////////////////////////////////////////////////
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(64'(rdata), 64'(exp));
  endtask : rd_reg
  // Slot must open a few cycles after start microseconds of 125 cycles
  task wait_out(input int sel, input int lo);
    int n;
    n = 0;
    while (n < 2000 && !(sel == 0 ? rx === 1'b1 : sel == 1 ? dn === 1'b1 : tx === 1'b1)) begin
      @(posedge clk);
      #1 n++;
    end
    chk(64'(cyc - t_pre >= lo && cyc - t_pre <= lo + 3), 64'h1);
  endtask : wait_out
  //////////////////////////////////////////////////////////////////////
  task t_regs;
    wr_reg(cta_pkg::REG_CTRL, 32'h00000121);
    rd_reg(cta_pkg::REG_CTRL, 32'h00000121);
    wr_reg(cta_pkg::REG_STATUS, 32'hffffffff);
    rd_reg(cta_pkg::REG_STATUS, 32'h00000000);
    rd_reg(8'h10, 32'h00000000);
  endtask : t_regs
  task t_sched;
    seen = 0;
    i_host.send_mmc(el, 0);
    chk(64'(seen), 64'h1);
    chk(cap, 64'h8786858483828180);
    wait_out(0, 250);
    chk({ep, s_set}, {4'h5, 1'b1});
    wait_out(1, 500);
    chk({rx, tx, ep}, 6'h00);
    wait_out(2, 750);
    chk({ep, tx_in, s_set}, {4'h3, 1'b1, 1'b0});
    rd_reg(cta_pkg::REG_STATUS, 32'h00000083);
  endtask : t_sched
  task t_foreign;
    wr_reg(cta_pkg::REG_CTRL, 32'h00000122);
    rx_seen = 1'b0;
    seen = 0;
    el[5] = 8'h99;
    i_host.send_mmc(el, 0);
    wait_out(1, 500);
    chk(64'({rx_seen, tx}), 64'h0);
    chk(64'(seen), 64'h0);
    chk(s_data, 64'h8786858483828180);
    el[5] = 8'h80;
    wr_reg(cta_pkg::REG_CTRL, 32'h00000121);
  endtask : t_foreign
  task t_out;
    i_host.send_mmc({8'h20, 8'h42, 8'h01, 8'h00, 8'h21}, 0);
    wait_out(2, 125);
    chk({ep, tx_in, s_set}, {4'h2, 1'b0, 1'b0});
  endtask : t_out
  task t_ovf;
    logic [7:0] b[$];
    b = {8'h20};
    for (int k = 0; k < 9; k++) begin
      b = {b, 8'h80, 8'(8'h10 + k), 8'h00};
    end
    i_host.send_mmc(b, 0);
    rd_reg(cta_pkg::REG_STATUS, 32'h00000028);
  endtask : t_ovf
  task t_bad;
    i_host.send_mmc({8'h20, 8'hc0, 8'h01, 8'h00}, 0);
    rd_reg(cta_pkg::REG_STATUS, 32'h00000040);
    i_host.send_mmc({8'h20, 8'h00}, 3);
    rd_reg(cta_pkg::REG_STATUS, 32'h00000010);
    i_host.send_mmc({8'h20, 8'h80, 8'h01, 8'h00, 8'h42, 8'h02}, 0);
    rd_reg(cta_pkg::REG_STATUS, 32'h00000011);
  endtask : t_bad
  task final_report;
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    // Receive with setup, notification, then IN transmit, rising start times
    el = {8'h20, 8'h25, 8'h02, 8'h00, 8'h21, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
      8'h86, 8'h87, 8'h80, 8'h04, 8'h00, 8'h53, 8'h06, 8'h00, 8'h21};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_sched();
    t_foreign();
    t_out();
    t_bad();
    t_ovf();
    final_report();
  end
endmodule : tb
